// file: rtl/blqp_bulk_ptr.sv
// Purpose: Holds the bulk list current pointer
// Assumes: Advance, reload and software write are decided by the caller
// Notes: Reload has priority over advance, advance over software write
`timescale 1ns/1ps
module blqp_bulk_ptr (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sw_wr,
  input wire logic [31:0] sw_data,
  input wire logic advance,
  input wire logic [31:0] next_link,
  input wire logic reload,
  input wire logic [31:0] head,
  output logic [31:0] ptr
);

  typedef struct packed {
    logic [31:0] ptr;
  } blqp_bulk_state_t;

  blqp_bulk_state_t st_r;
  blqp_bulk_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (reload) begin
      st_nxt.ptr = head & blqp_pkg::BLQP_ADDR_MASK;
    end else if (advance) begin
      st_nxt.ptr = next_link & blqp_pkg::BLQP_ADDR_MASK;
    end else if (sw_wr) begin
      st_nxt.ptr = sw_data & blqp_pkg::BLQP_ADDR_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_r.ptr <= blqp_pkg::BLQP_PTR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ptr = st_r.ptr;

endmodule

// file: rtl/blqp_done_head.sv
// Purpose: Holds the done queue head pointer
// Assumes: Completion and flush arrive as one-cycle pulses
// Notes: A completion in the flush cycle survives; flush takes the older head
`timescale 1ns/1ps
module blqp_done_head (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sw_wr,
  input wire logic [31:0] sw_data,
  input wire logic td_done,
  input wire logic [31:0] td_addr,
  input wire logic flush,
  output logic [31:0] head
);

  typedef struct packed {
    logic [31:0] head;
  } blqp_done_state_t;

  blqp_done_state_t st_r;
  blqp_done_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (td_done) begin
      st_nxt.head = td_addr & blqp_pkg::BLQP_ADDR_MASK;
    end else if (flush) begin
      st_nxt.head = blqp_pkg::BLQP_PTR_RESET;
    end else if (sw_wr) begin
      st_nxt.head = sw_data & blqp_pkg::BLQP_ADDR_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_r.head <= blqp_pkg::BLQP_PTR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign head = st_r.head;

endmodule

// file: rtl/blqp_pkg.sv
// Purpose: Constants and types shared by the bulk list and done queue pointer logic
// Assumes: 32-bit register data, byte offsets from the memory base
// Notes: Offsets are relative to the memory base taken from configuration space
package blqp_pkg;

  localparam logic [7:0] BLQP_CFG_MEM_BASE_OFS = 8'h10;
  localparam logic [7:0] BLQP_OFS_BULK_CUR = 8'h2C;
  localparam logic [7:0] BLQP_OFS_DONE_HEAD = 8'h30;

  localparam int BLQP_ADDR_LSB = 4;
  localparam int BLQP_ADDR_MSB = 31;
  localparam logic [31:0] BLQP_ADDR_MASK = 32'hFFFFFFF0;
  localparam logic [31:0] BLQP_PTR_RESET = 32'h00000000;
  localparam logic [31:0] BLQP_END_OF_LIST = 32'h00000000;

  localparam int BLQP_LIST_FILLED_BIT = 1;
  localparam int BLQP_BULK_ENABLE_BIT = 5;

  typedef enum logic [1:0] {
    BLQP_ST_IDLE = 2'b00,
    BLQP_ST_FETCH = 2'b01,
    BLQP_ST_END_CHECK = 2'b10
  } blqp_state_t;

endpackage

// file: rtl/blqp_top.sv
// Purpose: Bulk list current pointer and done queue head pointer engine
// Assumes: Register port offsets are relative to the memory base of either function
// Notes: Descriptor fetch and memory writes are done by engines outside
`timescale 1ns/1ps
module blqp_top (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_offset,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  input wire logic [31:0] command_status_register,
  input wire logic [31:0] operation_control_register,
  input wire logic [31:0] bulk_list_head_pointer,
  output logic list_filled_clear,
  input wire logic frame_start,
  input wire logic bulk_slot,
  output logic ed_fetch_req,
  output logic [31:0] ed_fetch_addr,
  input wire logic ed_served,
  input wire logic [31:0] next_descriptor_link,
  input wire logic td_complete,
  input wire logic [31:0] td_complete_addr,
  output logic td_link_wr,
  output logic [31:0] td_link_addr,
  output logic [31:0] td_link_data,
  input wire logic host_communication_area_update,
  output logic host_communication_area_wr,
  output logic [31:0] host_communication_area_done_head,
  output logic [31:0] bulk_current_address_field
);

  typedef struct packed {
    blqp_pkg::blqp_state_t fsm;
    logic [31:0] reg_rdata;
    logic reg_ack;
    logic list_filled_clear;
    logic ed_fetch_req;
    logic [31:0] ed_fetch_addr;
    logic td_link_wr;
    logic [31:0] td_link_addr;
    logic [31:0] td_link_data;
    logic host_communication_area_wr;
    logic [31:0] host_communication_area_done_head;
  } blqp_top_state_t;

  blqp_top_state_t st_r;
  blqp_top_state_t st_nxt;

  logic [31:0] bulk_ptr;
  logic [31:0] done_head;
  logic bulk_enable;
  logic list_filled;
  logic bulk_sw_wr;
  logic done_sw_wr;
  logic advance;
  logic reload;

  function automatic logic hit(input logic [7:0] ofs, input logic [7:0] target);
    hit = (ofs == target);
  endfunction

  // Reserved bits are ignored so a stray low bit cannot hide a list end
  function automatic logic list_end(input logic [31:0] link);
    list_end = ((link & blqp_pkg::BLQP_ADDR_MASK) == blqp_pkg::BLQP_END_OF_LIST);
  endfunction

  assign bulk_enable = operation_control_register[blqp_pkg::BLQP_BULK_ENABLE_BIT];
  assign list_filled = command_status_register[blqp_pkg::BLQP_LIST_FILLED_BIT];

  // Writes while bulk is running are dropped, the engine owns the pointer
  assign bulk_sw_wr = reg_wr && hit(reg_offset, blqp_pkg::BLQP_OFS_BULK_CUR) && !bulk_enable;
  assign done_sw_wr = reg_wr && hit(reg_offset, blqp_pkg::BLQP_OFS_DONE_HEAD);

  assign advance = (st_r.fsm == blqp_pkg::BLQP_ST_FETCH) && ed_served;
  assign reload = (st_r.fsm == blqp_pkg::BLQP_ST_END_CHECK) && list_filled;

  blqp_bulk_ptr u_bulk (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sw_wr(bulk_sw_wr),
    .sw_data(reg_wdata),
    .advance(advance),
    .next_link(next_descriptor_link),
    .reload(reload),
    .head(bulk_list_head_pointer),
    .ptr(bulk_ptr)
  );

  blqp_done_head u_done (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sw_wr(done_sw_wr),
    .sw_data(reg_wdata),
    .td_done(td_complete),
    .td_addr(td_complete_addr),
    .flush(host_communication_area_update),
    .head(done_head)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.reg_ack = 1'b0;
    st_nxt.list_filled_clear = 1'b0;
    st_nxt.td_link_wr = 1'b0;
    st_nxt.host_communication_area_wr = 1'b0;

    // Register read port, unmapped offsets read zero
    if (reg_rd || reg_wr) begin
      st_nxt.reg_ack = 1'b1;
    end
    if (reg_rd) begin
      if (hit(reg_offset, blqp_pkg::BLQP_OFS_BULK_CUR)) begin
        st_nxt.reg_rdata = bulk_ptr;
      end else if (hit(reg_offset, blqp_pkg::BLQP_OFS_DONE_HEAD)) begin
        st_nxt.reg_rdata = done_head;
      end else begin
        st_nxt.reg_rdata = 32'h00000000;
      end
    end

    unique case (st_r.fsm)
      blqp_pkg::BLQP_ST_IDLE: begin
        st_nxt.ed_fetch_req = 1'b0;
        // Frame start never touches the pointer, so work resumes where it stopped
        if (bulk_enable && bulk_slot && !frame_start) begin
          if (list_end(bulk_ptr)) begin
            st_nxt.fsm = blqp_pkg::BLQP_ST_END_CHECK;
          end else begin
            st_nxt.fsm = blqp_pkg::BLQP_ST_FETCH;
            st_nxt.ed_fetch_req = 1'b1;
            st_nxt.ed_fetch_addr = bulk_ptr;
          end
        end
      end
      blqp_pkg::BLQP_ST_FETCH: begin
        if (ed_served) begin
          st_nxt.ed_fetch_req = 1'b0;
          if (list_end(next_descriptor_link)) begin
            st_nxt.fsm = blqp_pkg::BLQP_ST_END_CHECK;
          end else begin
            st_nxt.fsm = blqp_pkg::BLQP_ST_IDLE;
          end
        end
      end
      blqp_pkg::BLQP_ST_END_CHECK: begin
        st_nxt.ed_fetch_req = 1'b0;
        if (list_filled) begin
          st_nxt.list_filled_clear = 1'b1;
        end
        st_nxt.fsm = blqp_pkg::BLQP_ST_IDLE;
      end
      default: begin
        st_nxt.fsm = blqp_pkg::BLQP_ST_IDLE;
        st_nxt.ed_fetch_req = 1'b0;
      end
    endcase

    // Link gets the old head, or zero when a flush in the same cycle already took it
    if (td_complete) begin
      st_nxt.td_link_wr = 1'b1;
      st_nxt.td_link_addr = td_complete_addr & blqp_pkg::BLQP_ADDR_MASK;
      st_nxt.td_link_data = host_communication_area_update ? blqp_pkg::BLQP_PTR_RESET : done_head;
    end
    if (host_communication_area_update) begin
      st_nxt.host_communication_area_wr = 1'b1;
      st_nxt.host_communication_area_done_head = done_head;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_r.fsm <= blqp_pkg::BLQP_ST_IDLE;
      st_r.reg_rdata <= 32'h00000000;
      st_r.reg_ack <= 1'b0;
      st_r.list_filled_clear <= 1'b0;
      st_r.ed_fetch_req <= 1'b0;
      st_r.ed_fetch_addr <= blqp_pkg::BLQP_PTR_RESET;
      st_r.td_link_wr <= 1'b0;
      st_r.td_link_addr <= blqp_pkg::BLQP_PTR_RESET;
      st_r.td_link_data <= blqp_pkg::BLQP_PTR_RESET;
      st_r.host_communication_area_wr <= 1'b0;
      st_r.host_communication_area_done_head <= blqp_pkg::BLQP_PTR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.reg_rdata;
  assign reg_ack = st_r.reg_ack;
  assign list_filled_clear = st_r.list_filled_clear;
  assign ed_fetch_req = st_r.ed_fetch_req;
  assign ed_fetch_addr = st_r.ed_fetch_addr;
  assign td_link_wr = st_r.td_link_wr;
  assign td_link_addr = st_r.td_link_addr;
  assign td_link_data = st_r.td_link_data;
  assign host_communication_area_wr = st_r.host_communication_area_wr;
  assign host_communication_area_done_head = st_r.host_communication_area_done_head;
  assign bulk_current_address_field = bulk_ptr;

endmodule

// file: tb/blqp_top_props.sv
// Purpose: Port-level checks for the bulk and done head pointer block
// Assumes: One clock, synchronous active-low reset
// Notes: Bench never writes the bulk pointer while the engine is in an end check
`timescale 1ns/1ps
module blqp_chk (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_offset,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic [31:0] operation_control_register,
  input wire logic [31:0] bulk_list_head_pointer,
  input wire logic list_filled_clear,
  input wire logic ed_fetch_req,
  input wire logic [31:0] ed_fetch_addr,
  input wire logic ed_served,
  input wire logic [31:0] next_descriptor_link,
  input wire logic td_complete,
  input wire logic [31:0] td_complete_addr,
  input wire logic td_link_wr,
  input wire logic [31:0] td_link_addr,
  input wire logic host_communication_area_update,
  input wire logic host_communication_area_wr,
  input wire logic [31:0] bulk_current_address_field
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  logic [31:0] m;
  assign m = blqp_pkg::BLQP_ADDR_MASK;
  a_ack_follows_req: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("ack missing");
  a_ack_has_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd)) else $error("stray ack");
  a_read_live_ptr: assert property (reg_rd && reg_offset == 8'h2C |=>
    reg_rdata == $past(bulk_current_address_field)) else $error("stale bulk read");
  a_low_bits_zero: assert property (bulk_current_address_field[3:0] == 4'h0) else $error("low bits set");
  a_sw_write_idle: assert property (reg_wr && reg_offset == 8'h2C && !operation_control_register[5] &&
    !ed_fetch_req |=> bulk_current_address_field == ($past(reg_wdata) & m)) else $error("write lost");
  a_advance_link: assert property (ed_fetch_req && ed_served |=>
    bulk_current_address_field == ($past(next_descriptor_link) & m)) else $error("no advance");
  a_fetch_addr_ptr: assert property (ed_fetch_req |-> ed_fetch_addr == bulk_current_address_field)
    else $error("fetch address wrong");
  a_reload_head: assert property (list_filled_clear |->
    bulk_current_address_field == (bulk_list_head_pointer & m) ##1 !list_filled_clear) else $error("bad reload");
  a_td_link_wr: assert property (td_complete |=> td_link_wr && td_link_addr == ($past(td_complete_addr) & m))
    else $error("link write wrong");
  a_host_communication_area_pulse: assert property (host_communication_area_update |=> host_communication_area_wr) else $error("no done head flush");
  a_reset_zero: assert property (disable iff (1'h0) !rst_b |=>
    bulk_current_address_field == 32'h0 && !reg_ack) else $error("reset value wrong");
endmodule

bind blqp_top blqp_chk u_chk (.*);

// file: tb/blqp_top_tb_top.sv
// Purpose: Self-checking bench for the bulk and done head pointer block
// Assumes: Inputs change on the falling edge; seed starts at 97
// Notes: Flag owner is modelled inline; it clears the flag on the clear pulse
`timescale 1ns/1ps
module blqp_top_tb_top;
  logic sys_clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, frame_start = 1'h0, bulk_slot = 1'h0;
  logic ed_served = 1'h0, td_complete = 1'h0, host_communication_area_update = 1'h0;
  logic reg_ack, list_filled_clear, ed_fetch_req, td_link_wr, host_communication_area_wr;
  logic [7:0] reg_offset = 8'h0;
  logic [31:0] reg_wdata = 32'h0, command_status_register = 32'h0, operation_control_register = 32'h0;
  logic [31:0] bulk_list_head_pointer = 32'h0, next_descriptor_link = 32'h0, td_complete_addr = 32'h0;
  logic [31:0] reg_rdata, ed_fetch_addr, td_link_addr, td_link_data, host_communication_area_done_head, bulk_current_address_field;
  logic [31:0] lst [4];
  integer seed = 97, err_total = 0, checked = 0, i;
  always #2.5 sys_clk = ~sys_clk;
  blqp_top dut (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("mismatches=%0d compares=%0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One strobe cycle; ack is due exactly one edge later
  task automatic rw(input logic w, input logic [7:0] off, input logic [31:0] d);
    reg_wr = w;
    reg_rd = !w;
    reg_offset = off;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    chk(reg_ack, 32'h1);
    @(negedge sys_clk);
  endtask
  task automatic wait_hi(input logic sel);
    int k;
    for (k = 0; k < 50 && !(sel ? list_filled_clear : ed_fetch_req); k++) @(negedge sys_clk);
    if (k == 50) begin
      err_total = err_total + 1;
      stop_test;
    end
  endtask
  task automatic serve(input logic [31:0] exp, input logic [31:0] nxt);
    wait_hi(1'h0);
    chk(ed_fetch_addr, exp);
    ed_served = 1'h1;
    next_descriptor_link = nxt;
    @(negedge sys_clk);
    ed_served = 1'h0;
    chk(bulk_current_address_field, nxt & blqp_pkg::BLQP_ADDR_MASK);
  endtask
  task automatic td(input logic [31:0] a, input logic [31:0] old);
    td_complete = 1'h1;
    td_complete_addr = a;
    @(negedge sys_clk);
    td_complete = 1'h0;
    chk(td_link_data, old);
    chk(td_link_addr, a);
    @(negedge sys_clk);
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    rst_b = 1'h1;
    @(negedge sys_clk);
    rw(1'h0, 8'h2C, 32'h0);
    chk(reg_rdata, 32'h0);
    rw(1'h0, 8'h30, 32'h0);
    chk(reg_rdata, 32'h0);
    rw(1'h0, 8'h34, 32'h0);
    chk(reg_rdata, 32'h0);
    for (i = 0; i < 4; i++) lst[i] = ($random(seed) & blqp_pkg::BLQP_ADDR_MASK) | 32'h100;
    bulk_list_head_pointer = lst[0];
    rw(1'h1, 8'h2C, lst[3]);
    rw(1'h0, 8'h2C, 32'h0);
    chk(reg_rdata, lst[3]);
    rw(1'h1, 8'h2C, lst[0]);
    operation_control_register = 32'h20;
    rw(1'h1, 8'h2C, lst[3]);
    rw(1'h0, 8'h2C, 32'h0);
    chk(reg_rdata, lst[0]);
    bulk_slot = 1'h1;
    serve(lst[0], lst[1]);
    // New frame must pick up where the last one stopped
    bulk_slot = 1'h0;
    frame_start = 1'h1;
    @(negedge sys_clk);
    frame_start = 1'h0;
    bulk_slot = 1'h1;
    serve(lst[1], lst[2]);
    rw(1'h0, 8'h2C, 32'h0);
    chk(reg_rdata, lst[2]);
    serve(lst[2], 32'h5);
    repeat (4) begin
      @(negedge sys_clk);
      chk(list_filled_clear, 32'h0);
    end
    command_status_register = 32'h2;
    wait_hi(1'h1);
    command_status_register = 32'h0;
    chk(bulk_current_address_field, lst[0]);
    serve(lst[0], 32'h0);
    bulk_slot = 1'h0;
    operation_control_register = 32'h0;
    td(lst[1], 32'h0);
    td(lst[3], lst[1]);
    rw(1'h0, 8'h30, 32'h0);
    chk(reg_rdata, lst[3]);
    host_communication_area_update = 1'h1;
    @(negedge sys_clk);
    host_communication_area_update = 1'h0;
    chk(host_communication_area_done_head, lst[3]);
    rw(1'h0, 8'h30, 32'h0);
    chk(reg_rdata, 32'h0);
    rw(1'h1, 8'h30, lst[2]);
    rw(1'h0, 8'h30, 32'h0);
    chk(reg_rdata, lst[2]);
    // Completion in the flush cycle: flush takes the old head, link gets zero
    host_communication_area_update = 1'h1;
    td_complete = 1'h1;
    td_complete_addr = lst[0];
    @(negedge sys_clk);
    host_communication_area_update = 1'h0;
    td_complete = 1'h0;
    chk(td_link_data, 32'h0);
    chk(host_communication_area_done_head, lst[2]);
    rw(1'h0, 8'h30, 32'h0);
    chk(reg_rdata, lst[0]);
    stop_test;
  end
endmodule
